// ===== include/smrc_pkg.sv
package smrc_pkg;
  // Bus geometry
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  // Register byte addresses
  localparam logic [31:0] SMC_ADDR = 32'hFFFF0440;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'hFFFF0444;
  localparam logic [31:0] IRQ_CLEAR_ADDR = 32'hFFFF0448;
  localparam logic [31:0] IRQ_ENABLE_ADDR = 32'hFFFF044C;
  localparam logic [31:0] ROC_ADDR = 32'hFFFF0480;
  // Supply monitor control fields
  localparam int SMC_FLAG_BIT = 0;
  localparam int SMC_EN_BIT = 1;
  localparam int SMC_TRIP_BIT = 2;
  localparam int SMC_CMP_BIT = 3;
  localparam logic [15:0] SMC_RESET = 16'h0008;
  // Reference output control fields
  localparam int ROC_W = 8;
  localparam int ROC_1V2_BIT = 0;
  localparam int ROC_2V5_BIT = 1;
  localparam int ROC_BUF_BIT = 2;
  localparam logic [7:0] ROC_RESET = 8'h01;
  localparam logic [7:0] ROC_MASK = 8'h07;
  // Interrupt event layout
  localparam int EV_W = 4;
  localparam int EV_FLAG_SET = 0;
  localparam int EV_CMP_FALL = 1;
  localparam int EV_CMP_RISE = 2;
  localparam int EV_CLR_REFUSED = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // Comparator idles high: supply good or monitor off
  localparam logic CMP_IDLE = 1'b1;
  typedef enum logic [1:0] {
    MON_OFF,
    MON_GOOD,
    MON_LOW,
    MON_HELD
  } smrc_mon_state_t;
endpackage : smrc_pkg

// ===== include/smrc_irq_if.sv
`timescale 1ns/1ns
interface smrc_irq_if;
  import smrc_pkg::*;
  logic [EV_W-1:0] event_pulse;
  logic clear_wr;
  logic [EV_W-1:0] clear_mask;
  logic enable_wr;
  logic [EV_W-1:0] enable_data;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] enable;
  logic irq;
  modport producer (
    output event_pulse, clear_wr, clear_mask, enable_wr, enable_data,
    input status, enable, irq
  );
  modport collector (
    input event_pulse, clear_wr, clear_mask, enable_wr, enable_data,
    output status, enable, irq
  );
endinterface : smrc_irq_if

// ===== design/smrc_sync.sv
`timescale 1ns/1ns
module smrc_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Level crossing
  input wire logic async_in,
  output logic sync_out
);
  import smrc_pkg::*;
  logic stage1_reg;
  logic stage2_reg;
  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_reg <= CMP_IDLE;
      stage2_reg <= CMP_IDLE;
    end else if (ce) begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end
  assign sync_out = stage2_reg;
endmodule : smrc_sync

// ===== design/smrc_irq.sv
`timescale 1ns/1ns
module smrc_irq (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Event and register side
  smrc_irq_if.collector irq_bus
);
  import smrc_pkg::*;
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] status_next;
  logic [EV_W-1:0] enable_reg;
  logic irq_reg;
  genvar i;
  // Set beats clear so no event is lost
  generate
    for (i = 0; i < EV_W; i++) begin : g_bit
      assign status_next[i] = irq_bus.event_pulse[i] |
        (status_reg[i] & ~(irq_bus.clear_wr & irq_bus.clear_mask[i]));
    end
  endgenerate
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= IRQ_RESET;
    end else if (ce) begin
      status_reg <= status_next;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg <= IRQ_RESET;
    end else if (ce && irq_bus.enable_wr) begin
      enable_reg <= irq_bus.enable_data;
    end
  end
  // Registered from current state, one cycle behind status
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= |(status_reg & enable_reg);
    end
  end
  assign irq_bus.status = status_reg;
  assign irq_bus.enable = enable_reg;
  assign irq_bus.irq = irq_reg;
endmodule : smrc_irq

// ===== design/smrc_top.sv
// Behaviour
// RULE1 - Reference bit 2 drives both buffered reference outputs from 2.5 V.
// RULE2 - Reference bit 1 connects the 2.5 V reference to its pin.
// RULE3 - Reference bit 0 connects the 1.2 V reference to its pin.
// RULE4 - Reference control resets with only the 1.2 V enable set.
// RULE5 - Monitor bit 3 is read-only live comparator state.
// RULE6 - Status reads one when supply good or monitor off, else zero.
// RULE7 - Monitor bit 2 picks trip level: zero low level, one high level.
// RULE8 - Monitor bit 1 enables or disables the monitor circuit.
// RULE9 - Monitor bit 0 flag is set whenever comparator status is low.
// RULE10 - Writing one to bit 0 clears the flag once status is high.
// RULE11 - Writing zero to bit 0 leaves the flag alone.
// RULE12 - No clear delay; flag clearable the cycle status returns high.
// RULE13 - Flag goes out as the low-supply request to the interrupt core.
// RULE14 - Status still low keeps the flag; no new interrupt until high.
// RULE15 - Monitor control resets to status set, all else clear.
// RULE16 - Software keeps the monitor off during debug port use.
// RULE17 - Reserved bits read zero and ignore writes.
// RULE18 - Comparator output passes a two-stage synchronizer first.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
module smrc_top (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic [smrc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [smrc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [smrc_pkg::DATA_W-1:0] reg_rdata,
  // Supply comparator
  input wire logic comparator_raw,
  output logic monitor_enable,
  output logic trip_level_select,
  // Reference switches
  output logic ref_2v5_out_en,
  output logic ref_1v2_out_en,
  output logic buffered_reference_out_a,
  output logic buffered_reference_out_b,
  // Interrupts
  output logic low_supply_req,
  output logic irq
);
  import smrc_pkg::*;

  // Register state
  logic [ROC_W-1:0] roc_reg;
  logic monitor_enable_reg;
  logic trip_level_reg;
  logic low_supply_flag_reg;
  logic low_supply_flag_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic low_supply_req_reg;
  logic buf_a_reg;
  logic buf_b_reg;

  // Comparator path
  logic cmp_sync;
  logic comparator_status;
  logic comparator_status_prev_reg;
  logic cmp_fall;
  logic cmp_rise;

  // Decode
  logic hit_smc;
  logic hit_roc;
  logic hit_status;
  logic hit_clear;
  logic hit_enable;
  logic wr_smc;
  logic wr_roc;
  logic flag_clear_req;
  logic flag_clear_ok;

  // Monitor sequencing
  smrc_mon_state_t mon_state_reg;
  smrc_mon_state_t mon_state_next;
  logic [EV_W-1:0] events;

  smrc_irq_if irq_bus ();

  // Comparator arrives asynchronous to sys_clk
  smrc_sync u_cmp_sync ( // RULE18
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .async_in(comparator_raw),
    .sync_out(cmp_sync)
  );

  smrc_irq u_irq (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .irq_bus(irq_bus)
  );

  // Address decode; full 32-bit compare, no aliasing
  assign hit_smc = (reg_addr == SMC_ADDR);
  assign hit_roc = (reg_addr == ROC_ADDR);
  assign hit_status = (reg_addr == IRQ_STATUS_ADDR);
  assign hit_clear = (reg_addr == IRQ_CLEAR_ADDR);
  assign hit_enable = (reg_addr == IRQ_ENABLE_ADDR);
  assign wr_smc = reg_wr && hit_smc;
  assign wr_roc = reg_wr && hit_roc;

  // Powered-down monitor reads as supply good, whatever the pin does
  assign comparator_status = monitor_enable_reg ? cmp_sync : CMP_IDLE; // RULE6

  assign cmp_fall = comparator_status_prev_reg && !comparator_status;
  assign cmp_rise = !comparator_status_prev_reg && comparator_status;

  // Only a one in bit 0 asks for a clear
  assign flag_clear_req = wr_smc && reg_wdata[SMC_FLAG_BIT]; // RULE11
  // Honoured at once while status is high, no hold-off
  assign flag_clear_ok = flag_clear_req && comparator_status; // RULE10 RULE12

  // Reference control register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      roc_reg <= ROC_RESET; // RULE4
    end else if (ce && wr_roc) begin
      roc_reg <= reg_wdata[ROC_W-1:0] & ROC_MASK; // RULE17
    end
  end

  // Buffered outputs follow bit 2 together
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_a_reg <= ROC_RESET[ROC_BUF_BIT];
      buf_b_reg <= ROC_RESET[ROC_BUF_BIT];
    end else if (ce && wr_roc) begin
      buf_a_reg <= reg_wdata[ROC_BUF_BIT]; // RULE1
      buf_b_reg <= reg_wdata[ROC_BUF_BIT]; // RULE1
    end
  end

  assign ref_2v5_out_en = roc_reg[ROC_2V5_BIT]; // RULE2
  assign ref_1v2_out_en = roc_reg[ROC_1V2_BIT]; // RULE3
  assign buffered_reference_out_a = buf_a_reg;
  assign buffered_reference_out_b = buf_b_reg;

  // Monitor enable; bit 3 is never written
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      monitor_enable_reg <= SMC_RESET[SMC_EN_BIT]; // RULE15
    end else if (ce && wr_smc) begin
      monitor_enable_reg <= reg_wdata[SMC_EN_BIT]; // RULE8 RULE5
    end
  end

  // Trip level select
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_level_reg <= SMC_RESET[SMC_TRIP_BIT]; // RULE15
    end else if (ce && wr_smc) begin
      trip_level_reg <= reg_wdata[SMC_TRIP_BIT]; // RULE7
    end
  end

  assign monitor_enable = monitor_enable_reg;
  assign trip_level_select = trip_level_reg;

  // Low status keeps the flag up; clear cannot win while low
  always_comb begin
    low_supply_flag_next = low_supply_flag_reg;
    if (!comparator_status) begin
      low_supply_flag_next = 1'b1; // RULE9 RULE14
    end else if (flag_clear_ok) begin
      low_supply_flag_next = 1'b0; // RULE10
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_supply_flag_reg <= SMC_RESET[SMC_FLAG_BIT]; // RULE15
    end else if (ce) begin
      low_supply_flag_reg <= low_supply_flag_next;
    end
  end

  // Level request to the interrupt core; its enables sit there
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_supply_req_reg <= 1'b0;
    end else if (ce) begin
      low_supply_req_reg <= low_supply_flag_next; // RULE13
    end
  end
  assign low_supply_req = low_supply_req_reg;

  // Edge history of the live status
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      comparator_status_prev_reg <= CMP_IDLE;
    end else if (ce) begin
      comparator_status_prev_reg <= comparator_status;
    end
  end

  // Monitor sequencing: tracks where a low-supply episode stands
  always_comb begin
    mon_state_next = mon_state_reg;
    case (mon_state_reg)
      MON_OFF: begin
        if (monitor_enable_reg) begin
          mon_state_next = comparator_status ? MON_GOOD : MON_LOW;
        end
      end
      MON_GOOD: begin
        if (!comparator_status) begin
          mon_state_next = MON_LOW;
        end else if (!monitor_enable_reg) begin
          mon_state_next = MON_OFF;
        end
      end
      MON_LOW: begin
        // Flag pinned until status is back high
        if (comparator_status) begin
          mon_state_next = MON_HELD; // RULE14
        end
      end
      MON_HELD: begin
        if (!comparator_status) begin
          mon_state_next = MON_LOW;
        end else if (flag_clear_ok || !low_supply_flag_reg) begin
          mon_state_next = monitor_enable_reg ? MON_GOOD : MON_OFF;
        end
      end
      default: begin
        mon_state_next = MON_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mon_state_reg <= MON_OFF;
    end else if (ce) begin
      mon_state_reg <= mon_state_next;
    end
  end

  // Event pulses into the sticky status bits
  always_comb begin
    events = IRQ_RESET;
    events[EV_FLAG_SET] = low_supply_flag_next && !low_supply_flag_reg;
    events[EV_CMP_FALL] = cmp_fall;
    events[EV_CMP_RISE] = cmp_rise;
    // Software tried to clear too early; useful to catch a short ISR
    events[EV_CLR_REFUSED] = flag_clear_req && !comparator_status;
  end

  // Events are held off while frozen so none fire twice
  assign irq_bus.event_pulse = ce ? events : IRQ_RESET;
  assign irq_bus.clear_wr = reg_wr && hit_clear;
  assign irq_bus.clear_mask = reg_wdata[EV_W-1:0];
  assign irq_bus.enable_wr = reg_wr && hit_enable;
  assign irq_bus.enable_data = reg_wdata[EV_W-1:0];
  assign irq = irq_bus.irq;

  // Read mux; unmapped and write-only addresses read zero
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      if (hit_smc) begin
        rdata_next[SMC_FLAG_BIT] = low_supply_flag_reg;
        rdata_next[SMC_EN_BIT] = monitor_enable_reg;
        rdata_next[SMC_TRIP_BIT] = trip_level_reg;
        rdata_next[SMC_CMP_BIT] = comparator_status; // RULE5 RULE17
      end else if (hit_roc) begin
        rdata_next[ROC_W-1:0] = roc_reg; // RULE17
      end else if (hit_status) begin
        rdata_next[EV_W-1:0] = irq_bus.status;
      end else if (hit_enable) begin
        rdata_next[EV_W-1:0] = irq_bus.enable;
      end
    end
  end

  // Data stand for one cycle only, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

endmodule : smrc_top

// ===== verification/smrc_cmp_model.sv
`timescale 1ns/1ns
module smrc_cmp_model #(
  parameter int TRIP_LO_MV = 2790,
  parameter int TRIP_HI_MV = 3070
) (
  // Control from the block
  input wire logic monitor_enable,
  input wire logic trip_level_select,
  // Supply level in millivolts
  input wire logic [15:0] supply_mv,
  // Comparator output
  output logic comparator_raw
);
  // Powered down reads as supply good
  assign comparator_raw = !monitor_enable ? 1'b1 :
    supply_mv > (trip_level_select ? TRIP_HI_MV : TRIP_LO_MV);
endmodule : smrc_cmp_model

// ===== verification/smrc_asserts.sv
`timescale 1ns/1ns
module smrc_chk (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic [smrc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [smrc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [smrc_pkg::DATA_W-1:0] reg_rdata,
  // Far side
  input wire logic comparator_raw,
  input wire logic monitor_enable,
  input wire logic trip_level_select,
  input wire logic ref_2v5_out_en,
  input wire logic ref_1v2_out_en,
  input wire logic buffered_reference_out_a,
  input wire logic buffered_reference_out_b,
  input wire logic low_supply_req
);
  import smrc_pkg::*;
  logic smc_wr;
  logic roc_wr;
  logic smc_rd;
  logic roc_rd;
  logic flag_clr;
  assign smc_wr = ce && reg_wr && reg_addr == SMC_ADDR;
  assign roc_wr = ce && reg_wr && reg_addr == ROC_ADDR;
  assign smc_rd = ce && reg_rd && reg_addr == SMC_ADDR;
  assign roc_rd = ce && reg_rd && reg_addr == ROC_ADDR;
  assign flag_clr = smc_wr && reg_wdata[SMC_FLAG_BIT];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_ref_buf: assert property (
    roc_wr |=> buffered_reference_out_a == $past(reg_wdata[ROC_BUF_BIT])
    && buffered_reference_out_b == buffered_reference_out_a)
    else $error("buffered reference outputs wrong");
  a_ref_2v5: assert property (
    roc_wr |=> ref_2v5_out_en == $past(reg_wdata[ROC_2V5_BIT]))
    else $error("2.5 V enable wrong");
  a_ref_1v2: assert property (
    roc_wr |=> ref_1v2_out_en == $past(reg_wdata[ROC_1V2_BIT]))
    else $error("1.2 V enable wrong");
  a_reset_values: assert property (
    $rose(rst_b) |-> ref_1v2_out_en && !ref_2v5_out_en && !monitor_enable
    && !trip_level_select && !low_supply_req)
    else $error("outputs wrong after reset");
  a_mon_write: assert property (
    smc_wr |=> monitor_enable == $past(reg_wdata[SMC_EN_BIT])
    && trip_level_select == $past(reg_wdata[SMC_TRIP_BIT]))
    else $error("monitor controls not written");
  a_smc_read: assert property (
    smc_rd |=> reg_rdata[15:4] == 12'h000 && reg_rdata[2:1] ==
    {$past(trip_level_select), $past(monitor_enable)})
    else $error("monitor control read wrong");
  a_roc_read: assert property (
    roc_rd |=> reg_rdata == {13'h0, $past(buffered_reference_out_a),
    $past(ref_2v5_out_en), $past(ref_1v2_out_en)})
    else $error("reference control read wrong");
  a_flag_set: assert property (
    (monitor_enable && !comparator_raw && ce) [*3] |=> low_supply_req)
    else $error("low supply flag not set");
  a_flag_hold: assert property (
    low_supply_req && !flag_clr |=> low_supply_req)
    else $error("low supply flag lost");
  a_flag_clear: assert property (
    flag_clr && !monitor_enable |=> !low_supply_req)
    else $error("low supply flag not cleared");
endmodule : smrc_chk

bind smrc_top smrc_chk i_smrc_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .comparator_raw(comparator_raw),
  .monitor_enable(monitor_enable), .trip_level_select(trip_level_select),
  .ref_2v5_out_en(ref_2v5_out_en), .ref_1v2_out_en(ref_1v2_out_en),
  .buffered_reference_out_a(buffered_reference_out_a),
  .buffered_reference_out_b(buffered_reference_out_b),
  .low_supply_req(low_supply_req)
);

// ===== verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  import smrc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic comparator_raw, monitor_enable, trip_level_select, irq;
  logic ref_2v5_out_en, ref_1v2_out_en, buf_a, buf_b, low_supply_req;
  logic [15:0] supply_mv = 16'h0CE4;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #50 sys_clk = ~sys_clk;

  smrc_top i_smrc_top (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .comparator_raw(comparator_raw),
    .monitor_enable(monitor_enable), .trip_level_select(trip_level_select),
    .ref_2v5_out_en(ref_2v5_out_en), .ref_1v2_out_en(ref_1v2_out_en),
    .buffered_reference_out_a(buf_a), .buffered_reference_out_b(buf_b),
    .low_supply_req(low_supply_req), .irq(irq)
  );
  smrc_cmp_model i_smrc_cmp_model (
    .monitor_enable(monitor_enable), .trip_level_select(trip_level_select),
    .supply_mv(supply_mv), .comparator_raw(comparator_raw)
  );

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #10;
    check(reg_rdata, exp);
  endtask : rd

  task t_reset;
    rd(ROC_ADDR, 16'h0001);
    rd(SMC_ADDR, 16'h0008);
    $display("reset test done");
  endtask : t_reset

  task t_ref;
    for (int v = 0; v < 8; v++) begin
      wr(ROC_ADDR, 16'hFFF8 | 16'(v));
      rd(ROC_ADDR, 16'(v));
      check(16'(ref_1v2_out_en), 16'(v & 1));
      check(16'(ref_2v5_out_en), 16'((v >> 1) & 1));
      check(16'({buf_a, buf_b}), 16'((v >> 2) * 3));
    end
    wr(32'hFFFF0500, 16'h0000);
    rd(ROC_ADDR, 16'h0007);
    rd(32'hFFFF0500, 16'h0000);
    $display("reference test done");
  endtask : t_ref

  task t_monitor;
    supply_mv <= 16'h0B54;
    wr(SMC_ADDR, 16'h0002);
    rd(SMC_ADDR, 16'h000A);
    // Upper trip level puts the supply below it
    wr(SMC_ADDR, 16'hFFF6);
    repeat (4) @(posedge sys_clk);
    rd(SMC_ADDR, 16'h0007);
    check(16'(low_supply_req), 16'h0001);
    wr(SMC_ADDR, 16'h0007);
    rd(SMC_ADDR, 16'h0007);
    wr(IRQ_ENABLE_ADDR, 16'h000F);
    rd(IRQ_STATUS_ADDR, 16'h000B);
    check(16'(irq), 16'h0001);
    // Clear lands in the first cycle the status is high again
    @(posedge sys_clk);
    supply_mv <= 16'h0C80;
    @(posedge sys_clk);
    wr(SMC_ADDR, 16'h0007);
    rd(SMC_ADDR, 16'h000E);
    wr(IRQ_CLEAR_ADDR, 16'h000F);
    rd(IRQ_STATUS_ADDR, 16'h0000);
    check(16'(irq), 16'h0000);
    supply_mv <= 16'h09C4;
    repeat (4) @(posedge sys_clk);
    wr(SMC_ADDR, 16'h0001);
    rd(SMC_ADDR, 16'h0009);
    wr(SMC_ADDR, 16'h0001);
    rd(SMC_ADDR, 16'h0008);
    $display("monitor test done");
  endtask : t_monitor

  // Write lands while frozen, so it must be lost
  task t_freeze;
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(ROC_ADDR, 16'h0000);
    ce <= 1'b1;
    rd(ROC_ADDR, 16'h0007);
    check(16'(ref_1v2_out_en), 16'h0001);
    $display("freeze test done");
  endtask : t_freeze

  task finish_test;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // Whole run takes about 90 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test;
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset;
    t_ref;
    t_freeze;
    // No debug session in this bench, so the monitor may run
    t_monitor;
    finish_test;
  end
endmodule : testbench
